// ### src/dpm_pkg.sv
package dpm_pkg;

   // -----------------------------------------------------------------
   // Protection states, one-hot
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      DPM_BOOT = 4'h1,
      DPM_OPEN = 4'h2,
      DPM_PROT = 4'h4,
      DPM_KILL = 4'h8
   } dpm_mode_t;

   // -----------------------------------------------------------------
   // Codes written to or loaded into the protection state register
   // -----------------------------------------------------------------
   localparam logic [1:0] CODE_BOOT = 2'h0;
   localparam logic [1:0] CODE_OPEN = 2'h1;
   localparam logic [1:0] CODE_PROT = 2'h2;
   localparam logic [1:0] CODE_KILL = 2'h3;

   // -----------------------------------------------------------------
   // Debug access classes
   // -----------------------------------------------------------------
   localparam logic [1:0] DAP_USER_MEM  = 2'h0;
   localparam logic [1:0] DAP_REGISTER  = 2'h1;
   localparam logic [1:0] DAP_FLASH_REG = 2'h2;
   localparam logic [1:0] DAP_ACQUIRE   = 2'h3;

   // -----------------------------------------------------------------
   // Row protection levels and reset values
   // -----------------------------------------------------------------
   localparam logic       LVL_UNPROT  = 1'h0;
   localparam logic       LVL_FULL    = 1'h1;
   localparam logic       RST_DBG_EN  = 1'h1;
   localparam logic       RST_LOCKED  = 1'h0;
   localparam int         ROWS_DEF    = 16;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic       req;
      logic [1:0] kind;
   } dpm_dap_t;

   typedef struct packed {
      logic       req;
      logic       ext;
      logic       write;
   } dpm_row_acc_t;

   typedef struct packed {
      dpm_mode_t  mode;
      logic       dbgEn;
      logic       locked;
      logic       erasedSince;
      logic       eraseBusy;
      logic       nmi;
      logic       priv;
      logic       dapPend;
      logic       dapPrev;
      logic       dapAck;
      logic       dapDeny;
      logic       eraseGo;
      logic       eraseDeny;
      logic       rowOk;
      logic       rowDeny;
      logic [1:0] stateCode;
   } dpm_state_t;

endpackage : dpm_pkg

// ### src/dpm_sync.sv
`timescale 1ns/10ps
// Three-stage pin synchroniser; a change counts once stages two and three agree
module dpm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] s1Reg;
   logic [W-1:0] s2Reg;
   logic [W-1:0] s3Reg;
   logic [W-1:0] outReg;

   // Shift chain and agreement filter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1Reg  <= '0;
         s2Reg  <= '0;
         s3Reg  <= '0;
         outReg <= '0;
      end else begin
         s1Reg <= din;
         s2Reg <= s1Reg;
         s3Reg <= s2Reg;
         if (s2Reg == s3Reg) begin
            outReg <= s3Reg;
         end
      end
   end

   assign dout = outReg;

endmodule : dpm_sync

// ### src/dpm_row_prot.sv
`timescale 1ns/10ps
// Per-row protection level store; levels change only while an erase runs
module dpm_row_prot #(
   parameter int ROWS = 16,
   parameter int IW   = 4
) (
   input  wire logic            clk,
   input  wire logic            rstn,
   input  wire logic            lvlWr,
   input  wire logic            eraseBusy,
   input  wire logic [IW-1:0]   lvlIdx,
   input  wire logic            lvlVal,
   output logic      [ROWS-1:0] levels
);

   // One level flop per row
   genvar g;
   generate
      for (g = 0; g < ROWS; g++) begin : gRow
         logic lvlReg;
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               lvlReg <= dpm_pkg::LVL_UNPROT;
            end else if (lvlWr && eraseBusy && (lvlIdx == IW'(g))) begin
               lvlReg <= lvlVal;
            end
         end
         assign levels[g] = lvlReg;
      end
   endgenerate

endmodule : dpm_row_prot

// ### src/dpm_ctrl.sv
`timescale 1ns/10ps
module dpm_ctrl #(
   parameter int ROWS = dpm_pkg::ROWS_DEF,
   parameter int IW   = $clog2(dpm_pkg::ROWS_DEF)
) (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic                 loadValid,
   input  wire logic [1:0]           loadCode,
   input  wire logic                 loadLock,
   input  wire logic                 swWrEn,
   input  wire logic [1:0]           swWrCode,
   input  wire logic                 cpuPrivReq,
   input  wire logic                 fwDbgWr,
   input  wire logic                 fwDbgVal,
   input  wire logic                 fwLockReq,
   input  wire dpm_pkg::dpm_dap_t    dapPin,
   input  wire logic                 eraseReq,
   input  wire logic                 eraseDone,
   input  wire logic                 lvlWr,
   input  wire logic [IW-1:0]        lvlIdx,
   input  wire logic                 lvlVal,
   input  wire dpm_pkg::dpm_row_acc_t rowAcc,
   input  wire logic [IW-1:0]        rowIdx,
   output logic      [1:0]           stateCode,
   output logic                      cpuPriv,
   output logic                      nmiOut,
   output logic                      dbgEnabled,
   output logic                      devLocked,
   output logic                      dapAck,
   output logic                      dapDeny,
   output logic                      eraseGo,
   output logic                      eraseDeny,
   output logic                      eraseBusy,
   output logic                      rowOk,
   output logic                      rowDeny
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Decode a state code to the one-hot mode
   function automatic dpm_pkg::dpm_mode_t codeToMode(input logic [1:0] c);
      case (c)
         dpm_pkg::CODE_OPEN: codeToMode = dpm_pkg::DPM_OPEN;
         dpm_pkg::CODE_PROT: codeToMode = dpm_pkg::DPM_PROT;
         dpm_pkg::CODE_KILL: codeToMode = dpm_pkg::DPM_KILL;
         default:            codeToMode = dpm_pkg::DPM_BOOT;
      endcase
   endfunction : codeToMode

   // Encode the one-hot mode back to its code
   function automatic logic [1:0] modeToCode(input dpm_pkg::dpm_mode_t m);
      case (m)
         dpm_pkg::DPM_OPEN: modeToCode = dpm_pkg::CODE_OPEN;
         dpm_pkg::DPM_PROT: modeToCode = dpm_pkg::CODE_PROT;
         dpm_pkg::DPM_KILL: modeToCode = dpm_pkg::CODE_KILL;
         default:           modeToCode = dpm_pkg::CODE_BOOT;
      endcase
   endfunction : modeToCode

   // ----------------------------------------------------------------
   // Pin synchronisation and row levels
   // ----------------------------------------------------------------

   dpm_pkg::dpm_dap_t dapSync;
   logic [ROWS-1:0]   levels;
   dpm_pkg::dpm_state_t st_reg;
   dpm_pkg::dpm_state_t st_next;

   dpm_sync #(.W(3)) uDapSync (
      .clk  (clk),
      .rstn (rstn),
      .din  (dapPin),
      .dout (dapSync)
   );

   dpm_row_prot #(.ROWS(ROWS), .IW(IW)) uRowProt (
      .clk       (clk),
      .rstn      (rstn),
      .lvlWr     (lvlWr),
      .eraseBusy (st_reg.eraseBusy),
      .lvlIdx    (lvlIdx),
      .lvlVal    (lvlVal),
      .levels    (levels)
   );

   // ----------------------------------------------------------------
   // Access decisions
   // ----------------------------------------------------------------

   logic privEff;
   logic limitOn;
   logic dapAllowed;
   logic rowProt;
   logic rowAllowed;
   logic eraseAllowed;

   // Restriction terms for the debug, row and erase checks; limitOn feeds only the debug check
   always_comb begin
      privEff  = (st_reg.mode == dpm_pkg::DPM_BOOT) | cpuPrivReq;
      limitOn  = (st_reg.mode != dpm_pkg::DPM_OPEN) | privEff;
      case (dapSync.kind)
         dpm_pkg::DAP_USER_MEM,
         dpm_pkg::DAP_FLASH_REG: dapAllowed = !limitOn;
         default:                dapAllowed = 1'b1;
      endcase
      if (!st_reg.dbgEn || st_reg.locked) begin
         dapAllowed = 1'b0;
      end
      rowProt = (levels[rowIdx] == dpm_pkg::LVL_FULL);
      if (!rowProt) begin
         rowAllowed = 1'b1;
      end else if (rowAcc.write) begin
         rowAllowed = 1'b0;
      end else begin
         rowAllowed = !(rowAcc.ext && (st_reg.mode == dpm_pkg::DPM_PROT));
      end
      eraseAllowed = (st_reg.mode != dpm_pkg::DPM_KILL) && !st_reg.locked
                     && (st_reg.mode != dpm_pkg::DPM_BOOT) && !st_reg.eraseBusy;
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------

   // Protection state, debug control, erase and access answers
   always_comb begin
      st_next           = st_reg;
      st_next.dapAck    = 1'b0;
      st_next.dapDeny   = 1'b0;
      st_next.eraseGo   = 1'b0;
      st_next.eraseDeny = 1'b0;
      st_next.rowOk     = 1'b0;
      st_next.rowDeny   = 1'b0;

      // State transitions
      case (st_reg.mode)
         dpm_pkg::DPM_BOOT: begin
            if (loadValid) begin
               st_next.mode   = codeToMode(loadCode);
               st_next.locked = loadLock;
            end
         end
         dpm_pkg::DPM_OPEN: begin
            if (swWrEn && (swWrCode == dpm_pkg::CODE_PROT)) begin
               st_next.mode        = dpm_pkg::DPM_PROT;
               st_next.erasedSince = 1'b0;
            end else if (swWrEn && (swWrCode == dpm_pkg::CODE_KILL)) begin
               st_next.mode = dpm_pkg::DPM_KILL;
            end
         end
         dpm_pkg::DPM_PROT: begin
            if (swWrEn && (swWrCode == dpm_pkg::CODE_OPEN)
                && st_reg.erasedSince) begin
               st_next.mode = dpm_pkg::DPM_OPEN;
            end
         end
         dpm_pkg::DPM_KILL: begin
            st_next.mode = dpm_pkg::DPM_KILL;
         end
         default: begin
            st_next.mode = dpm_pkg::DPM_BOOT;
         end
      endcase
      // Other writes fall through the case unchanged

      // Erase completion, set wins over the clear on entering protected
      if (eraseDone && st_reg.eraseBusy) begin
         st_next.eraseBusy   = 1'b0;
         st_next.erasedSince = 1'b1;
      end

      // Erase start
      if (eraseReq) begin
         if (eraseAllowed) begin
            st_next.eraseGo   = 1'b1;
            st_next.eraseBusy = 1'b1;
         end else begin
            st_next.eraseDeny = 1'b1;
         end
      end

      // Firmware debug enable and permanent lock
      if (fwDbgWr && (st_reg.mode != dpm_pkg::DPM_BOOT)) begin
         st_next.dbgEn = fwDbgVal;
      end
      if (fwLockReq && (st_reg.mode != dpm_pkg::DPM_BOOT)) begin
         st_next.locked = 1'b1;
      end

      // Debug answer held back in boot; a new request edge wins over the clear
      st_next.dapPrev = dapSync.req;
      if (st_reg.dapPend && (st_reg.mode != dpm_pkg::DPM_BOOT)) begin
         st_next.dapPend = 1'b0;
         st_next.dapAck  = dapAllowed;
         st_next.dapDeny = !dapAllowed;
      end
      if (dapSync.req && !st_reg.dapPrev) begin
         st_next.dapPend = 1'b1;
      end

      // Flash row access answer
      if (rowAcc.req) begin
         st_next.rowOk   = rowAllowed;
         st_next.rowDeny = !rowAllowed;
      end

      // Privilege and NMI follow the effective privilege level
      st_next.priv      = privEff;
      st_next.nmi       = privEff;
      st_next.stateCode = modeToCode(st_next.mode);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // Reset to boot with debug enabled
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg             <= '0;
         st_reg.mode        <= dpm_pkg::DPM_BOOT;
         st_reg.dbgEn       <= dpm_pkg::RST_DBG_EN;
         st_reg.locked      <= dpm_pkg::RST_LOCKED;
         st_reg.priv        <= 1'b1;
         st_reg.nmi         <= 1'b1;
         st_reg.stateCode   <= dpm_pkg::CODE_BOOT;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // All outputs come from the state register
   assign stateCode  = st_reg.stateCode;
   assign cpuPriv    = st_reg.priv;
   assign nmiOut     = st_reg.nmi;
   assign dbgEnabled = st_reg.dbgEn;
   assign devLocked  = st_reg.locked;
   assign dapAck     = st_reg.dapAck;
   assign dapDeny    = st_reg.dapDeny;
   assign eraseGo    = st_reg.eraseGo;
   assign eraseDeny  = st_reg.eraseDeny;
   assign eraseBusy  = st_reg.eraseBusy;
   assign rowOk      = st_reg.rowOk;
   assign rowDeny    = st_reg.rowDeny;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   a_boot_no_dap: assert property (
      @(posedge clk) disable iff (!rstn)
      (st_reg.mode == dpm_pkg::DPM_BOOT) |=> !(dapAck || dapDeny))
      else $error("debug answer given during boot");

   a_boot_priv_hold: assert property (
      @(posedge clk) disable iff (!rstn)
      $past(st_reg.mode == dpm_pkg::DPM_BOOT) |-> cpuPriv)
      else $error("cpu not privileged in boot");

   a_boot_load_exit: assert property (
      @(posedge clk) disable iff (!rstn)
      (st_reg.mode == dpm_pkg::DPM_BOOT) && !loadValid
      |=> (st_reg.mode == dpm_pkg::DPM_BOOT))
      else $error("boot left without load");

   a_kill_sticks: assert property (
      @(posedge clk) disable iff (!rstn)
      (st_reg.mode == dpm_pkg::DPM_KILL) |=> (st_reg.mode == dpm_pkg::DPM_KILL) [*2])
      else $error("kill state left");

   a_kill_no_erase: assert property (
      @(posedge clk) disable iff (!rstn)
      (st_reg.mode == dpm_pkg::DPM_KILL) && eraseReq |=> eraseDeny && !eraseGo)
      else $error("erase started in kill");

   a_prot_open_erase: assert property (
      @(posedge clk) disable iff (!rstn)
      $past(st_reg.mode == dpm_pkg::DPM_PROT) && (st_reg.mode == dpm_pkg::DPM_OPEN)
      |-> $past(st_reg.erasedSince))
      else $error("protected left without erase");

   a_legal_moves: assert property (
      @(posedge clk) disable iff (!rstn)
      (st_reg.mode == dpm_pkg::DPM_PROT) |=> (st_reg.mode != dpm_pkg::DPM_KILL))
      else $error("illegal protected to kill move");

   a_nmi_priv: assert property (
      @(posedge clk) disable iff (!rstn)
      cpuPrivReq |=> nmiOut && cpuPriv)
      else $error("nmi dropped while privileged");

   a_lock_refuse: assert property (
      @(posedge clk) disable iff (!rstn)
      devLocked && st_reg.dapPend && (st_reg.mode != dpm_pkg::DPM_BOOT)
      |=> dapDeny && !dapAck)
      else $error("locked device answered debug");

   a_row_write_deny: assert property (
      @(posedge clk) disable iff (!rstn)
      rowAcc.req && rowAcc.write && levels[rowIdx] |=> rowDeny)
      else $error("write to protected row allowed");

   a_open_user_ok: assert property (
      @(posedge clk) disable iff (!rstn)
      (st_reg.mode == dpm_pkg::DPM_OPEN) && !cpuPrivReq && st_reg.dbgEn
      && !st_reg.locked && st_reg.dapPend |=> dapAck)
      else $error("open user mode debug refused");

   a_prot_user_deny: assert property (
      @(posedge clk) disable iff (!rstn)
      (st_reg.mode == dpm_pkg::DPM_PROT) && st_reg.dapPend
      && (dapSync.kind == dpm_pkg::DAP_USER_MEM) |=> dapDeny)
      else $error("protected allowed user memory");

endmodule : dpm_ctrl

// ### verif/dpm_dbg_model.sv
`timescale 1ns/10ps
// Debugger on the debug access port: one request at a time
module dpm_dbg_model (
   input  wire logic         clk,
   input  wire logic         dapAck,
   input  wire logic         dapDeny,
   output dpm_pkg::dpm_dap_t dapPin,
   output logic              pending
);
   // Pins idle low
   initial begin
      dapPin  = '0;
      pending = 1'h0;
   end

   // Kind settles first; request held until answered, then a long low phase
   task automatic access(input logic [1:0] kind, output logic gotAck, output logic gotAny);
      gotAck = 1'h0;
      gotAny = 1'h0;
      @(negedge clk);
      dapPin.kind = kind;
      @(negedge clk);
      dapPin.req = 1'h1;
      pending    = 1'h1;
      for (int n = 0; n < 400 && !gotAny; n++) begin
         @(negedge clk);
         gotAck = (dapAck === 1'h1);
         gotAny = gotAck || (dapDeny === 1'h1);
      end
      dapPin  = '{req: 1'h0, kind: ~kind}; // Released kind lines do not keep the value
      pending = 1'h0;
      repeat (6) @(negedge clk); // Lets the synchroniser see the fall
   endtask : access
endmodule : dpm_dbg_model

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic                  clk = 1'h0;
   logic                  rstn, loadValid, loadLock, swWrEn, cpuPrivReq, fwDbgWr;
   logic                  fwDbgVal, fwLockReq, eraseReq, eraseDone, lvlWr, lvlVal;
   logic                  cpuPriv, nmiOut, dbgEnabled, devLocked, dapAck, dapDeny;
   logic                  eraseGo, eraseDeny, eraseBusy, rowOk, rowDeny;
   logic                  pending, gotAck, gotAny;
   logic [1:0]            loadCode, swWrCode, stateCode;
   logic [3:0]            lvlIdx, rowIdx;
   dpm_pkg::dpm_dap_t     dapPin;
   dpm_pkg::dpm_row_acc_t rowAcc;
   int                    fail_count = 0;
   int                    cmp_count = 0;

   // ------------------------------------------------------------
   // Clock, design and debugger
   // ------------------------------------------------------------
   always #25 clk = ~clk;

   dpm_ctrl uut (.clk, .rstn, .loadValid, .loadCode, .loadLock, .swWrEn, .swWrCode,
      .cpuPrivReq, .fwDbgWr, .fwDbgVal, .fwLockReq, .dapPin, .eraseReq, .eraseDone,
      .lvlWr, .lvlIdx, .lvlVal, .rowAcc, .rowIdx, .stateCode, .cpuPriv, .nmiOut,
      .dbgEnabled, .devLocked, .dapAck, .dapDeny, .eraseGo, .eraseDeny, .eraseBusy,
      .rowOk, .rowDeny);

   dpm_dbg_model dbgModel (.clk, .dapAck, .dapDeny, .dapPin, .pending);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input logic [1:0] got, input logic [1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic restart(input logic doLoad, input logic [1:0] code, input logic lock);
      @(negedge clk);
      rstn = 1'h0;
      repeat (4) @(negedge clk);
      rstn = 1'h1;
      if (doLoad) begin
         @(negedge clk);
         {loadValid, loadCode, loadLock} = {1'h1, code, lock};
         @(negedge clk);
         loadValid = 1'h0;
         @(negedge clk);
      end
   endtask : restart

   task automatic swWrite(input logic [1:0] code, input logic [1:0] exp);
      @(negedge clk);
      {swWrEn, swWrCode} = {1'h1, code};
      @(negedge clk);
      swWrEn = 1'h0;
      check(stateCode, exp);
   endtask : swWrite

   task automatic dbg(input logic [1:0] kind, input logic expAck);
      dbgModel.access(kind, gotAck, gotAny);
      check(2'(gotAny), 2'h1);
      check(2'(gotAck), 2'(expAck));
   endtask : dbg

   task automatic lvlPulse(input logic [3:0] idx, input logic val);
      @(negedge clk);
      {lvlWr, lvlIdx, lvlVal} = {1'h1, idx, val};
      @(negedge clk);
      lvlWr = 1'h0;
   endtask : lvlPulse

   task automatic erase(input logic expGo, input logic doLvl, input logic [3:0] idx);
      @(negedge clk);
      eraseReq = 1'h1;
      @(negedge clk);
      eraseReq = 1'h0;
      check(2'(eraseGo), 2'(expGo));
      check(2'(eraseDeny), 2'(!expGo));
      if (expGo) begin
         check(2'(eraseBusy), 2'h1);
         if (doLvl) lvlPulse(idx, dpm_pkg::LVL_FULL);
         @(negedge clk);
         eraseDone = 1'h1;
         @(negedge clk);
         eraseDone = 1'h0;
         check(2'(eraseBusy), 2'h0);
      end
   endtask : erase

   task automatic rowCheck(input logic [3:0] idx, input logic ext, input logic wr,
                           input logic expOk);
      @(negedge clk);
      rowAcc = '{req: 1'h1, ext: ext, write: wr};
      rowIdx = idx;
      @(negedge clk);
      rowAcc = '0;
      check(2'(rowOk), 2'(expOk));
      check(2'(rowDeny), 2'(!expOk));
   endtask : rowCheck

   task automatic fwPulse(input logic lk, input logic wr, input logic val);
      @(negedge clk);
      {fwLockReq, fwDbgWr, fwDbgVal} = {lk, wr, val};
      @(negedge clk);
      {fwLockReq, fwDbgWr} = 2'h0;
      @(negedge clk);
   endtask : fwPulse

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic s_boot;
      restart(1'h0, 2'h0, 1'h0);
      @(negedge clk);
      check(stateCode, dpm_pkg::CODE_BOOT);
      check(2'(cpuPriv), 2'h1);
      check(2'(nmiOut), 2'h1);
      check(2'(dbgEnabled), 2'h1);
      // Debugger stalls until the loader delivers the state
      fork
         dbgModel.access(dpm_pkg::DAP_REGISTER, gotAck, gotAny);
         begin
            repeat (20) @(negedge clk);
            check(2'(pending), 2'h1);
            check(stateCode, dpm_pkg::CODE_BOOT);
            {loadValid, loadCode} = {1'h1, dpm_pkg::CODE_OPEN};
            @(negedge clk);
            loadValid = 1'h0;
         end
      join
      check(2'(gotAck), 2'h1);
      check(stateCode, dpm_pkg::CODE_OPEN);
      check(2'(cpuPriv), 2'h0);
   endtask : s_boot

   task automatic s_open;
      for (int k = 0; k < 4; k++) dbg(2'(k), 1'h1);
      @(negedge clk);
      cpuPrivReq = 1'h1;
      repeat (2) @(negedge clk);
      check(2'(cpuPriv), 2'h1);
      dbg(dpm_pkg::DAP_USER_MEM, 1'h0);
      dbg(dpm_pkg::DAP_FLASH_REG, 1'h0);
      dbg(dpm_pkg::DAP_REGISTER, 1'h1);
      check(2'(nmiOut), 2'h1);
      cpuPrivReq = 1'h0;
      repeat (2) @(negedge clk);
      check(2'(nmiOut), 2'h0);
   endtask : s_open

   task automatic s_rows;
      erase(1'h1, 1'h1, 4'h5);
      lvlPulse(4'h6, dpm_pkg::LVL_FULL);
      rowCheck(4'h5, 1'h0, 1'h1, 1'h0);
      rowCheck(4'h5, 1'h1, 1'h1, 1'h0);
      rowCheck(4'h5, 1'h0, 1'h0, 1'h1);
      rowCheck(4'h5, 1'h1, 1'h0, 1'h1);
      rowCheck(4'h6, 1'h1, 1'h1, 1'h1);
      rowCheck(4'h6, 1'h0, 1'h1, 1'h1);
      rowCheck(4'h6, 1'h1, 1'h0, 1'h1);
   endtask : s_rows

   task automatic s_prot;
      swWrite(dpm_pkg::CODE_PROT, dpm_pkg::CODE_PROT);
      dbg(dpm_pkg::DAP_USER_MEM, 1'h0);
      dbg(dpm_pkg::DAP_FLASH_REG, 1'h0);
      dbg(dpm_pkg::DAP_REGISTER, 1'h1);
      rowCheck(4'h5, 1'h1, 1'h0, 1'h0);
      rowCheck(4'h5, 1'h0, 1'h0, 1'h1);
      swWrite(dpm_pkg::CODE_KILL, dpm_pkg::CODE_PROT);
      swWrite(dpm_pkg::CODE_OPEN, dpm_pkg::CODE_PROT);
      erase(1'h1, 1'h0, 4'h0);
      swWrite(dpm_pkg::CODE_OPEN, dpm_pkg::CODE_OPEN);
   endtask : s_prot

   task automatic s_kill;
      swWrite(dpm_pkg::CODE_KILL, dpm_pkg::CODE_KILL);
      dbg(dpm_pkg::DAP_USER_MEM, 1'h0);
      dbg(dpm_pkg::DAP_FLASH_REG, 1'h0);
      dbg(dpm_pkg::DAP_REGISTER, 1'h1);
      erase(1'h0, 1'h0, 4'h0);
      swWrite(dpm_pkg::CODE_OPEN, dpm_pkg::CODE_KILL);
      swWrite(dpm_pkg::CODE_PROT, dpm_pkg::CODE_KILL);
      restart(1'h1, dpm_pkg::CODE_KILL, 1'h0);
      check(stateCode, dpm_pkg::CODE_KILL);
      erase(1'h0, 1'h0, 4'h0);
   endtask : s_kill

   task automatic s_lock;
      restart(1'h1, dpm_pkg::CODE_OPEN, 1'h1);
      check(2'(devLocked), 2'h1);
      dbg(dpm_pkg::DAP_ACQUIRE, 1'h0);
      erase(1'h0, 1'h0, 4'h0);
      restart(1'h1, dpm_pkg::CODE_OPEN, 1'h0);
      fwPulse(1'h1, 1'h0, 1'h0);
      check(2'(devLocked), 2'h1);
      dbg(dpm_pkg::DAP_REGISTER, 1'h0);
      restart(1'h1, dpm_pkg::CODE_OPEN, 1'h0);
      fwPulse(1'h0, 1'h1, 1'h0);
      check(2'(dbgEnabled), 2'h0);
      dbg(dpm_pkg::DAP_REGISTER, 1'h0);
      erase(1'h1, 1'h0, 4'h0);
      fwPulse(1'h0, 1'h1, 1'h1);
      dbg(dpm_pkg::DAP_REGISTER, 1'h1);
   endtask : s_lock

   // ------------------------------------------------------------
   // Verdict, main sequence and watchdog
   // ------------------------------------------------------------
   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   // All inputs defined at time zero, then the scenarios in order
   initial begin
      {rstn, loadValid, loadLock, swWrEn, cpuPrivReq, fwDbgWr} = '0;
      {fwDbgVal, fwLockReq, eraseReq, eraseDone, lvlWr, lvlVal} = '0;
      {loadCode, swWrCode, lvlIdx, rowIdx} = '0;
      rowAcc = '0;
      s_boot;
      s_open;
      s_rows;
      s_prot;
      s_kill;
      s_lock;
      tally_and_finish;
   end

   // About 18 debug transfers of 14 cycles plus resets; 20000 is ample
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      tally_and_finish;
   end
endmodule : testbench
